//--- hw/touch_i2c_target.sv
// i2c target giving host access to control bytes and the touch report
// How it works
// - answers at 7-bit address 0x55 after reset; control byte 0 changes it
// - read returns byte at pointer, then successive addresses until host stops
// - later reads without new address start again at the stored pointer
// - written data bytes stored from start address upward, one per byte, below 0x10 only
// - pending touch data drives the interrupt request output low
// - report starts at 0x10, which is the pointer after reset
// - report byte 0 holds point count in low nibble, byte 1 key states
// - four-byte point record: flag byte, x low, y low, strength
// - up to five points reported, in absolute coordinates
`timescale 1ns/1ps
module touch_i2c_target (
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   output logic INT_N,
   input wire logic TOUCH_CLK,
   input wire logic REPORT_STROBE,
   input wire logic [touch_pkg::FINGER_W-1:0] REPORT_FINGERS,
   input wire logic [7:0] REPORT_KEYS,
   input wire logic [touch_pkg::NPTS-1:0] POINT_VALID,
   input wire touch_pkg::coords_type POINT_X,
   input wire touch_pkg::coords_type POINT_Y,
   input wire touch_pkg::strength_type POINT_Z,
   output logic REPORT_BUSY
);
   import touch_pkg::*;

   typedef struct packed {
      logic req;
      logic ack_m;
      logic ack_s;
      logic busy;
      logic [FINGER_W-1:0] fingers;
      logic [7:0] keys;
      logic [NPTS-1:0] valid;
      coords_type x;
      coords_type y;
      strength_type z;
   } sense_type;

   typedef struct packed {
      state_type state;
      logic scl_m;
      logic scl_s;
      logic scl_p;
      logic sda_m;
      logic sda_s;
      logic sda_p;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic first;
      logic nak;
      logic [7:0] ptr;
      logic [7:0] wadr;
      logic [7:0] radr;
      logic sda_oe;
      logic sda_o;
      ctrl_type ctrl;
      report_type rep;
      logic req_m;
      logic req_s;
      logic ack;
      logic pend;
      logic int_n;
   } core_type;

   sense_type sn_r, sn_nxt;
   core_type st_r, st_nxt;
   logic scl_rise, scl_fall, start_c, stop_c, load_en, new_rep;
   logic [7:0] load_adr, load_byte;

   function automatic report_type enc_report(input sense_type s);
      report_type r;
      int b;
      r = '0;
      r[0] = {4'h0, s.fingers};
      r[1] = s.keys;
      for (int i = 0; i < NPTS; i++) begin
         b = HEAD_BYTES + i * POINT_BYTES;
         r[b] = {s.valid[i], s.x[i][10:8], 1'b0, s.y[i][10:8]};
         r[b + 1] = s.x[i][7:0];
         r[b + 2] = s.y[i][7:0];
         r[b + 3] = s.z[i];
      end
      return r;
   endfunction

   function automatic logic [7:0] read_byte(input logic [7:0] adr, input ctrl_type c,
                                            input report_type r);
      logic [7:0] v;
      v = UNMAPPED_VAL;
      if (adr < CTRL_LIMIT) begin
         v = c[adr[3:0]];
      end else if (adr >= REPORT_BASE && adr < REPORT_END) begin
         v = r[5'(adr - REPORT_BASE)];
      end
      return v;
   endfunction

   // touch side: hold a report and hand it over by toggle handshake
   always_comb begin
      sn_nxt = sn_r;
      sn_nxt.ack_m = st_r.ack;
      sn_nxt.ack_s = sn_r.ack_m;
      if (REPORT_STROBE && !sn_r.busy) begin
         sn_nxt.fingers = REPORT_FINGERS;
         sn_nxt.keys = REPORT_KEYS;
         sn_nxt.valid = POINT_VALID;
         sn_nxt.x = POINT_X;
         sn_nxt.y = POINT_Y;
         sn_nxt.z = POINT_Z;
         sn_nxt.req = ~sn_r.req;
      end
      sn_nxt.busy = sn_nxt.req != sn_nxt.ack_s;
   end

   always_ff @(posedge TOUCH_CLK or negedge NRST) begin
      if (!NRST) begin
         sn_r <= '0;
      end else begin
         sn_r <= sn_nxt;
      end
   end

   assign scl_rise = st_r.scl_s && !st_r.scl_p;
   assign scl_fall = st_r.scl_p && !st_r.scl_s;
   assign start_c = st_r.scl_s && st_r.scl_p && st_r.sda_p && !st_r.sda_s;
   assign stop_c = st_r.scl_s && st_r.scl_p && !st_r.sda_p && st_r.sda_s;
   assign new_rep = st_r.state == ST_IDLE && st_r.req_s != st_r.ack;
   assign load_byte = read_byte(load_adr, st_r.ctrl, st_r.rep);

   // bus side: byte engine, register pointer and interrupt flag
   always_comb begin
      st_nxt = st_r;
      load_en = 1'b0;
      load_adr = st_r.radr;
      st_nxt.scl_m = SCL;
      st_nxt.scl_s = st_r.scl_m;
      st_nxt.scl_p = st_r.scl_s;
      st_nxt.sda_m = SDA_IN;
      st_nxt.sda_s = st_r.sda_m;
      st_nxt.sda_p = st_r.sda_s;
      st_nxt.req_m = sn_r.req;
      st_nxt.req_s = st_r.req_m;
      if (start_c) begin
         st_nxt.state = ST_ADDR;
         st_nxt.cnt = 4'h0;
         st_nxt.sda_oe = 1'b0;
      end else if (stop_c) begin
         st_nxt.state = ST_IDLE;
         st_nxt.sda_oe = 1'b0;
      end else begin
         case (st_r.state)
            ST_IDLE: begin
               st_nxt.sda_oe = 1'b0;
            end
            ST_ADDR, ST_RX: begin
               if (scl_rise) begin
                  st_nxt.sh = {st_r.sh[6:0], st_r.sda_s};
                  st_nxt.cnt = st_r.cnt + 4'h1;
               end else if (scl_fall && st_r.cnt == BYTE_BITS) begin
                  st_nxt.cnt = 4'h0;
                  if (st_r.state == ST_ADDR) begin
                     if (st_r.sh[7:1] == st_r.ctrl[CTRL_ADDR_IDX][6:0]) begin
                        st_nxt.state = ST_RXACK;
                        st_nxt.sda_oe = 1'b1;
                        st_nxt.rw = st_r.sh[0];
                        st_nxt.first = 1'b1;
                        st_nxt.radr = st_r.ptr;
                     end else begin
                        st_nxt.state = ST_IDLE;
                     end
                  end else begin
                     st_nxt.state = ST_RXACK;
                     st_nxt.sda_oe = 1'b1;
                     if (st_r.first) begin
                        st_nxt.first = 1'b0;
                        st_nxt.ptr = st_r.sh;
                        st_nxt.wadr = st_r.sh;
                     end else begin
                        if (st_r.wadr < CTRL_LIMIT) begin
                           st_nxt.ctrl[st_r.wadr[3:0]] = st_r.sh;
                        end
                        st_nxt.wadr = st_r.wadr + 8'h01;
                     end
                  end
               end
            end
            ST_RXACK: begin
               if (scl_fall) begin
                  if (st_r.rw) begin
                     load_en = 1'b1;
                  end else begin
                     st_nxt.state = ST_RX;
                     st_nxt.sda_oe = 1'b0;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (st_r.cnt == BYTE_BITS) begin
                     st_nxt.state = ST_TXACK;
                     st_nxt.sda_oe = 1'b0;
                  end else begin
                     st_nxt.sda_oe = ~st_r.sh[7];
                     st_nxt.sh = {st_r.sh[6:0], 1'b0};
                     st_nxt.cnt = st_r.cnt + 4'h1;
                  end
               end
            end
            ST_TXACK: begin
               if (scl_rise) begin
                  st_nxt.nak = st_r.sda_s;
               end else if (scl_fall) begin
                  if (st_r.nak) begin
                     st_nxt.state = ST_IDLE;
                  end else begin
                     load_en = 1'b1;
                     load_adr = st_r.radr + 8'h01;
                  end
               end
            end
            default: begin
               st_nxt.state = ST_IDLE;
               st_nxt.sda_oe = 1'b0;
            end
         endcase
      end
      if (load_en) begin
         st_nxt.state = ST_TX;
         st_nxt.radr = load_adr;
         st_nxt.sda_oe = ~load_byte[7];
         st_nxt.sh = {load_byte[6:0], 1'b0};
         st_nxt.cnt = 4'h1;
         if (load_adr == REPORT_BASE) begin
            st_nxt.pend = 1'b0;
         end
      end
      if (new_rep) begin
         st_nxt.rep = enc_report(sn_r);
         st_nxt.ack = st_r.req_s;
         st_nxt.pend = 1'b1;
      end
      st_nxt.int_n = ~st_nxt.pend;
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         st_r <= '0;
         st_r.state <= ST_IDLE;
         st_r.scl_m <= 1'b1;
         st_r.scl_s <= 1'b1;
         st_r.scl_p <= 1'b1;
         st_r.sda_m <= 1'b1;
         st_r.sda_s <= 1'b1;
         st_r.sda_p <= 1'b1;
         st_r.ptr <= REPORT_BASE;
         st_r.ctrl[CTRL_ADDR_IDX] <= {1'b0, I2C_ADDR_DEFAULT};
         st_r.int_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign SDA_OUT = st_r.sda_o;
   assign SDA_OE = st_r.sda_oe;
   assign INT_N = st_r.int_n;
   assign REPORT_BUSY = sn_r.busy;

   a_addr_match: assert property (@(posedge CLOCK) disable iff (!NRST)
      (st_r.state == ST_ADDR && !start_c && !stop_c && scl_fall && st_r.cnt == BYTE_BITS
       && st_r.sh[7:1] == st_r.ctrl[CTRL_ADDR_IDX][6:0]) |=> st_r.state == ST_RXACK && SDA_OE)
      else $error("own address not acknowledged");
   a_addr_reject: assert property (@(posedge CLOCK) disable iff (!NRST)
      (st_r.state == ST_ADDR && !start_c && !stop_c && scl_fall && st_r.cnt == BYTE_BITS
       && st_r.sh[7:1] != st_r.ctrl[CTRL_ADDR_IDX][6:0]) |=> st_r.state == ST_IDLE && !SDA_OE)
      else $error("foreign address acknowledged");
   a_read_start: assert property (@(posedge CLOCK) disable iff (!NRST)
      (st_r.state == ST_RXACK && st_r.rw && scl_fall && !start_c && !stop_c)
      |=> st_r.state == ST_TX && st_r.radr == $past(st_r.ptr))
      else $error("read not started at stored pointer");
   a_read_incr: assert property (@(posedge CLOCK) disable iff (!NRST)
      (st_r.state == ST_TXACK && scl_fall && !st_r.nak && !start_c && !stop_c)
      |=> st_r.radr == $past(st_r.radr) + 8'h01 ##1 st_r.state == ST_TX)
      else $error("read address did not advance");
   a_write_store: assert property (@(posedge CLOCK) disable iff (!NRST)
      (st_r.state == ST_RX && scl_fall && st_r.cnt == BYTE_BITS && !st_r.first
       && st_r.wadr < CTRL_LIMIT && !start_c && !stop_c)
      |=> st_r.ctrl[$past(st_r.wadr[3:0])] == $past(st_r.sh)
      && st_r.wadr == $past(st_r.wadr) + 8'h01)
      else $error("written byte not stored");
   a_irq_set: assert property (@(posedge CLOCK) disable iff (!NRST)
      new_rep |=> !INT_N [*2])
      else $error("interrupt not raised for new report");
   a_irq_release: assert property (@(posedge CLOCK) disable iff (!NRST)
      (load_en && load_adr == REPORT_BASE) |=> INT_N)
      else $error("interrupt kept after report read");
   a_report_head: assert property (@(posedge CLOCK) disable iff (!NRST)
      new_rep |=> st_r.rep[0] == {4'h0, $past(sn_r.fingers)} && st_r.rep[1] == $past(sn_r.keys))
      else $error("report header wrong");
   a_point_flags: assert property (@(posedge CLOCK) disable iff (!NRST)
      new_rep |=> st_r.rep[2] == {$past(sn_r.valid[0]), $past(sn_r.x[0][10:8]), 1'b0,
                                  $past(sn_r.y[0][10:8])} && st_r.rep[3] == $past(sn_r.x[0][7:0]))
      else $error("point record wrong");
   a_point_limit: assert property (@(posedge CLOCK) disable iff (!NRST)
      (load_en && load_adr >= REPORT_END)
      |=> SDA_OE == !UNMAPPED_VAL[7] && st_r.sh == {UNMAPPED_VAL[6:0], 1'b0})
      else $error("data beyond five points");
   a_report_base: assert property (@(posedge CLOCK) disable iff (!NRST)
      (load_en && load_adr == REPORT_BASE)
      |=> SDA_OE && st_r.sh[7:5] == 3'b000 && st_r.sh[4:1] == $past(st_r.rep[0][3:0]))
      else $error("report not at base address");

   c_read_byte: cover property (@(posedge CLOCK) disable iff (!NRST)
      st_r.state == ST_TXACK ##[1:1000] st_r.state == ST_TX);
   c_write_store: cover property (@(posedge CLOCK) disable iff (!NRST)
      st_r.state == ST_RX && !st_r.first && scl_fall && st_r.cnt == BYTE_BITS);
   c_irq_cycle: cover property (@(posedge CLOCK) disable iff (!NRST)
      $fell(INT_N) ##[1:1000] $rose(INT_N));
endmodule

//--- hw/touch_pkg.sv
// constants and types of the touch report register access block
package touch_pkg;
   localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h55;
   localparam logic [7:0] REPORT_BASE = 8'h10;
   localparam int REPORT_LEN = 22;
   localparam logic [7:0] REPORT_END = 8'h26;
   localparam int NPTS = 5;
   localparam int POINT_BYTES = 4;
   localparam int HEAD_BYTES = 2;
   localparam int CTRL_DEPTH = 16;
   localparam logic [7:0] CTRL_LIMIT = 8'h10;
   localparam logic [3:0] CTRL_ADDR_IDX = 4'h0;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [7:0] UNMAPPED_VAL = 8'h00;
   localparam int COORD_W = 11;
   localparam int FINGER_W = 4;

   typedef logic [COORD_W-1:0] coord_type;
   typedef logic [NPTS-1:0][COORD_W-1:0] coords_type;
   typedef logic [NPTS-1:0][7:0] strength_type;
   typedef logic [REPORT_LEN-1:0][7:0] report_type;
   typedef logic [CTRL_DEPTH-1:0][7:0] ctrl_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_RX,
      ST_RXACK,
      ST_TX,
      ST_TXACK
   } state_type;
endpackage

//--- verif/i2c_host_model.sv
// behavioural i2c bus controller standing in for the host processor
`timescale 1ns/1ps
module i2c_host_model (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask

   // one bit: data set mid-low, stable while scl high, sampled at end of high
   task automatic bit_io(input logic b, output logic r);
      wait_clk(4);
      sda_low <= ~b;
      wait_clk(6);
      scl <= 1'b1;
      wait_clk(10);
      r = sda;
      scl <= 1'b0;
   endtask

   task automatic start();
      wait_clk(4);
      sda_low <= 1'b0;
      wait_clk(6);
      scl <= 1'b1;
      wait_clk(10);
      sda_low <= 1'b1;
      wait_clk(10);
      scl <= 1'b0;
   endtask

   task automatic stop();
      wait_clk(4);
      sda_low <= 1'b1;
      wait_clk(6);
      scl <= 1'b1;
      wait_clk(10);
      sda_low <= 1'b0;
      wait_clk(10);
   endtask

   // msb first, then the acknowledge bit (a = 1 releases or sends nak)
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r,
                       output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(a, ack);
   endtask
endmodule

//--- verif/tb.sv
// self-checking bench of the touch report i2c target
`timescale 1ns/1ps
module tb;
   import touch_pkg::*;
   logic CLOCK = 1'b0;
   logic TOUCH_CLK = 1'b0;
   logic NRST = 1'b0;
   logic strobe = 1'b0;
   logic [FINGER_W-1:0] fingers = 4'h0;
   logic [7:0] keys = 8'h00;
   logic [NPTS-1:0] valid = 5'h00;
   coords_type px = '0;
   coords_type py = '0;
   strength_type pz = '0;
   logic [7:0] ctrl [16];
   logic [6:0] dev_addr = 7'h55;
   logic sda, scl, host_low, sda_out, sda_oe, int_n, busy, ack;
   logic [7:0] rd;
   int seed = 32'h4606;
   int num_errors = 0;
   int tests_run = 0;

   always #25 CLOCK = ~CLOCK;
   always #62.5 TOUCH_CLK = ~TOUCH_CLK;
   assign sda = ~((sda_oe & ~sda_out) | host_low);

   touch_i2c_target i_touch_i2c_target (.CLOCK(CLOCK), .NRST(NRST), .SCL(scl),
      .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .INT_N(int_n),
      .TOUCH_CLK(TOUCH_CLK), .REPORT_STROBE(strobe), .REPORT_FINGERS(fingers),
      .REPORT_KEYS(keys), .POINT_VALID(valid), .POINT_X(px), .POINT_Y(py),
      .POINT_Z(pz), .REPORT_BUSY(busy));
   i2c_host_model i_i2c_host_model (.clk(CLOCK), .sda(sda), .scl(scl), .sda_low(host_low));

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // expected register contents at one address
   function automatic logic [7:0] exp_reg(input logic [7:0] a);
      int p;
      int k;
      p = (int'(a) - 18) / 4;
      k = (int'(a) - 18) % 4;
      if (a < REPORT_BASE) return ctrl[a[3:0]];
      if (a >= REPORT_END) return 8'h00;
      if (a == REPORT_BASE) return {4'h0, fingers};
      if (a == 8'h11) return keys;
      case (k)
         0: return {valid[p], px[p][10:8], 1'b0, py[p][10:8]};
         1: return px[p][7:0];
         2: return py[p][7:0];
         default: return pz[p];
      endcase
   endfunction

   task automatic hdr(input logic rw, input logic [6:0] a, input logic exp_ack);
      i_i2c_host_model.start();
      i_i2c_host_model.xfer({a, rw}, 1'b1, rd, ack);
      chk(8'(ack), {7'h00, ~exp_ack});
   endtask

   task automatic set_ptr(input logic [7:0] p);
      hdr(1'b0, dev_addr, 1'b1);
      i_i2c_host_model.xfer(p, 1'b1, rd, ack);
      i_i2c_host_model.stop();
   endtask

   task automatic wr(input logic [7:0] ptr, input int n, input logic [7:0] d0,
                     input logic [7:0] d1);
      logic [7:0] d;
      hdr(1'b0, dev_addr, 1'b1);
      i_i2c_host_model.xfer(ptr, 1'b1, rd, ack);
      for (int i = 0; i < n; i++) begin
         d = (i == 0) ? d0 : d1;
         i_i2c_host_model.xfer(d, 1'b1, rd, ack);
         chk(8'(ack), 8'h00);
         if (int'(ptr) + i < 16) ctrl[4'(int'(ptr) + i)] = d;
      end
      i_i2c_host_model.stop();
      dev_addr = ctrl[0][6:0];
   endtask

   task automatic rd_cmp(input logic [7:0] base, input int n);
      hdr(1'b1, dev_addr, 1'b1);
      for (int i = 0; i < n; i++) begin
         i_i2c_host_model.xfer(8'hFF, i == n - 1, rd, ack);
         chk(rd, exp_reg(8'(int'(base) + i)));
      end
      i_i2c_host_model.stop();
   endtask

   task automatic post(input logic corner);
      @(posedge TOUCH_CLK);
      fingers <= corner ? 4'h5 : 4'($unsigned($random(seed)) % 6);
      keys <= 8'($random(seed));
      valid <= corner ? 5'h1F : 5'($random(seed));
      px <= corner ? '1 : 55'({$random(seed), $random(seed)});
      py <= corner ? '1 : 55'({$random(seed), $random(seed)});
      pz <= corner ? '1 : 40'({$random(seed), $random(seed)});
      strobe <= 1'b1;
      @(posedge TOUCH_CLK);
      strobe <= 1'b0;
      @(negedge TOUCH_CLK);
      chk(8'(busy), 8'h01);
      for (int i = 0; i < 400 && int_n !== 1'b0; i++) @(posedge CLOCK);
      chk(8'(int_n), 8'h00);
   endtask

   initial begin
      #3_000_000;
      num_errors++;
      stop_test();
   end

   initial begin
      for (int i = 0; i < 16; i++) ctrl[i] = 8'h00;
      ctrl[0] = 8'h55;
      repeat (5) @(posedge CLOCK);
      NRST <= 1'b1;
      repeat (3) @(posedge CLOCK);
      chk(8'(int_n), 8'h01);
      chk(8'(sda_oe), 8'h00);
      chk(8'(busy), 8'h00);
      for (int k = 0; k < 3; k++) begin
         post(k == 0);
         rd_cmp(REPORT_BASE, k == 1 ? 42 : REPORT_LEN);
         repeat (40) @(posedge CLOCK);
         chk(8'(int_n), 8'h01);
         chk(8'(busy), 8'h00);
         $display("report test %0d done", k);
      end
      rd_cmp(REPORT_BASE, 4);
      wr(8'h03, 2, 8'($random(seed)), 8'($random(seed)));
      set_ptr(8'h03);
      rd_cmp(8'h03, 2);
      wr(8'h0F, 2, 8'hA5, 8'h5A);
      set_ptr(8'h0F);
      rd_cmp(8'h0F, 2);
      $display("write test done");
      hdr(1'b0, 7'h54, 1'b0);
      i_i2c_host_model.stop();
      wr(8'h00, 1, 8'h23, 8'h00);
      hdr(1'b1, 7'h55, 1'b0);
      i_i2c_host_model.stop();
      set_ptr(8'h00);
      rd_cmp(8'h00, 1);
      wr(8'h00, 1, 8'h55, 8'h00);
      $display("address test done");
      stop_test();
   end
endmodule
